// ==== verilog/pms_pkg.sv ====
// Package for the power mode sequencer: register map, fields, modes, timing.
// Assumes a 125 MHz APB clock and a slow low-power oscillator tick from outside.
package pms_pkg;

  // Register byte offsets
  localparam logic [7:0] PMS_CTRL_OFS    = 8'h00;
  localparam logic [7:0] PMS_IDLE_OFS    = 8'h04;
  localparam logic [7:0] PMS_SLEEP_OFS   = 8'h08;
  localparam logic [7:0] PMS_DOFF_OFS    = 8'h0c;
  localparam logic [7:0] PMS_SNIFF_OFS   = 8'h10;
  localparam logic [7:0] PMS_RFCTL_OFS   = 8'h14;
  localparam logic [7:0] PMS_STATUS_OFS  = 8'h18;

  // Control register fields
  localparam int PMS_CTRL_AUTO_BIT   = 0;
  localparam int PMS_CTRL_REGDIS_BIT = 1;
  localparam int PMS_CTRL_SNIFF_BIT  = 2;
  localparam int PMS_CTRL_FORCE_BIT  = 3;
  localparam int PMS_CTRL_FMODE_LSB  = 4;

  // Software radio power-down field positions
  localparam int PMS_RF_TX_BIT  = 0;
  localparam int PMS_RF_RX_BIT  = 1;
  localparam int PMS_RF_PLL_BIT = 2;
  localparam int PMS_RF_PA_BIT  = 3;

  // Reset values
  localparam logic [31:0] PMS_CTRL_RST   = 32'h0000_0001;
  localparam logic [31:0] PMS_IDLE_RST   = 32'h0000_0100;
  localparam logic [31:0] PMS_SLEEP_RST  = 32'h0000_1000;
  localparam logic [31:0] PMS_DOFF_RST   = 32'h0001_0000;
  localparam logic [31:0] PMS_SNIFF_RST  = 32'h0000_0400;
  localparam logic [3:0]  PMS_RFCTL_RST  = 4'hf;

  // Inactivity counts are in low-power oscillator ticks
  localparam int PMS_CNT_W = 32;

  typedef enum logic [1:0] {
    PMS_ACTIVE   = 2'b00,
    PMS_IDLE     = 2'b01,
    PMS_SLEEP    = 2'b10,
    PMS_DEEP_OFF = 2'b11
  } pms_mode_t;

  // Radio power-down bundle toward the transceiver
  typedef struct packed {
    logic pa_pd;
    logic pll_pd;
    logic rx_pd;
    logic tx_pd;
  } pms_rf_pd_t;

endpackage

// ==== verilog/pms_power_manager.sv ====
// Power mode sequencer: steps down through four modes on inactivity, wakes on
// activity, drives radio power-downs and regulator enable; APB register slave.
// Assumes activity and low-power oscillator tick pins are asynchronous to pclk.
// Assumes the packet handler drives its radio requests from pclk.
// Limitation: pready never drops, so every transfer has no wait state.
//
// Notes on behaviour
// - Four modes: active, idle, sleep, deep-off.
// - Inactivity interval elapsed steps one mode lower.
// - Activity returns to active mode immediately.
// - Deep-off disables regulator output to core; here only when PMS_CTRL_REGDIS_BIT is set.
// - Always-on domain wakes chip on user event.
// - Separate radio power-downs: tx, rx, pll, pa.
// - Radio powered only during packet tx/rx; here the PLL also runs on pkt_pll_on alone.
// - Sniff runs on slow oscillator, timed wake.
// - Software may disable regulator in deep sleep.
// - Software registers and packet handler both control.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps

module pms_power_manager
  import pms_pkg::*;
#(
  parameter int CNT_W = PMS_CNT_W
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        user_event,
  input  wire logic        lpo_tick_in,
  input  wire logic        pkt_tx_active,
  input  wire logic        pkt_rx_active,
  input  wire logic        pkt_pll_on,
  output logic             regulator_output_en,
  output logic             core_clk_sel_lpo,
  output logic             sniff_wake,
  output pms_rf_pd_t       rf_pd,
  output logic      [1:0]  power_mode
);

  // Pin inputs: three-stage synchronisers
  logic [2:0] act_sync_q;
  logic [2:0] lpo_sync_q;
  logic       act_stable_q;
  logic       lpo_stable_q;
  logic       activity;
  logic       lpo_en;

  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] idle_lim_q;
  logic [31:0] sleep_lim_q;
  logic [31:0] doff_lim_q;
  logic [31:0] sniff_lim_q;
  logic [3:0]  rfctl_q;

  pms_mode_t       mode_q;
  pms_mode_t       mode_d;
  logic [CNT_W-1:0] inact_q;
  logic [CNT_W-1:0] sniff_q;
  logic [31:0]     limit;
  logic            wr_en;
  logic            rd_en;
  logic            addr_ok;
  // Helper terms kept apart so each rule reads on its own line
  logic            step_due;
  logic            sniff_due;
  logic            reg_cut;
  logic            lpo_sel;
  logic [31:0]     status_word;
  logic [31:0]     rd_word;
  logic [3:0]      rf_need;
  logic [3:0]      rf_pd_q;
  logic            radio_ok;

  // Counters compare with the 32-bit limit registers; no other width fits
  if (CNT_W != 32) begin : g_cnt_w_check
    $error("CNT_W must be 32 to match the limit registers");
  end

  // Synchronisers; a change counts once stages two and three agree
  // Stage one may go metastable, so only stage two reads it
  // The cost is three cycles of latency to the tick enable and four to each filtered level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sync_q <= 3'h0;
    end else begin
      act_sync_q <= {act_sync_q[1:0], user_event};
    end
  end

  // Slow oscillator clock pin, same three stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpo_sync_q <= 3'h0;
    end else begin
      lpo_sync_q <= {lpo_sync_q[1:0], lpo_tick_in};
    end
  end

  // Filtered activity level, only updated when the two late stages agree
  // A one-cycle glitch between stages two and three is dropped here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_stable_q <= 1'b0;
    end else begin
      if (act_sync_q[1] == act_sync_q[2]) act_stable_q <= act_sync_q[2];
    end
  end

  // Filtered slow clock level, same agreement rule
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpo_stable_q <= 1'b0;
    end else begin
      if (lpo_sync_q[1] == lpo_sync_q[2]) lpo_stable_q <= lpo_sync_q[2];
    end
  end

  // Activity is a level; the oscillator tick enable is a rising edge
  // The tick enable lasts one cycle however long the slow clock is high
  // Reset levels match the idle pins, so no false edge follows reset
  assign activity = act_stable_q;
  assign lpo_en   = (lpo_sync_q[1] == lpo_sync_q[2]) && lpo_sync_q[2] && !lpo_stable_q;

  // APB decode; zero wait states so pready is always high
  // Writes act in the access phase, reads are fetched in setup
  // Only aligned words of the map decode; the rest answer with an error
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  always_comb begin
    case (paddr)
      PMS_CTRL_OFS, PMS_IDLE_OFS, PMS_SLEEP_OFS, PMS_DOFF_OFS,
      PMS_SNIFF_OFS, PMS_RFCTL_OFS, PMS_STATUS_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Writable registers
  // Control keeps only its six defined bits, so reads show zeros above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= PMS_CTRL_RST;
      idle_lim_q  <= PMS_IDLE_RST;
      sleep_lim_q <= PMS_SLEEP_RST;
      doff_lim_q  <= PMS_DOFF_RST;
      sniff_lim_q <= PMS_SNIFF_RST;
      rfctl_q     <= PMS_RFCTL_RST;
    end else if (wr_en) begin
      case (paddr)
        PMS_CTRL_OFS:  ctrl_q      <= {26'h0, pwdata[5:0]};
        PMS_IDLE_OFS:  idle_lim_q  <= pwdata;
        PMS_SLEEP_OFS: sleep_lim_q <= pwdata;
        PMS_DOFF_OFS:  doff_lim_q  <= pwdata;
        PMS_SNIFF_OFS: sniff_lim_q <= pwdata;
        PMS_RFCTL_OFS: rfctl_q     <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Status word: regulator at bit 4, activity at bit 2, mode in bits 1:0
  // Status is read-only; writes to its offset are ignored
  assign status_word = {27'h0,
                        regulator_output_en,
                        1'b0,
                        act_stable_q,
                        mode_q};

  // Read mux over the register map; unmapped reads give zero
  always_comb begin
    case (paddr)
      PMS_CTRL_OFS:   rd_word = ctrl_q;
      PMS_IDLE_OFS:   rd_word = idle_lim_q;
      PMS_SLEEP_OFS:  rd_word = sleep_lim_q;
      PMS_DOFF_OFS:   rd_word = doff_lim_q;
      PMS_SNIFF_OFS:  rd_word = sniff_lim_q;
      PMS_RFCTL_OFS:  rd_word = {28'h0, rfctl_q};
      PMS_STATUS_OFS: rd_word = status_word;
      default:        rd_word = 32'h0;
    endcase
  end

  // Read data captured in setup so it is registered for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      prdata <= rd_word;
    end
  end

  // Always ready; unmapped addresses answer with an error
  // The error flag stands for the access phase only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Interval that applies to the current mode
  // Deep-off has no lower mode, so its limit is never used
  always_comb begin
    case (mode_q)
      PMS_ACTIVE: limit = idle_lim_q;
      PMS_IDLE:   limit = sleep_lim_q;
      PMS_SLEEP:  limit = doff_lim_q;
      default:    limit = 32'hffff_ffff;
    endcase
  end

  // Step-down due: auto on, slow tick now, interval used up
  // The compare uses count plus one so the step lands on the Nth tick
  assign step_due = ctrl_q[PMS_CTRL_AUTO_BIT] &&
                    lpo_en &&
                    (mode_q != PMS_DEEP_OFF) &&
                    (inact_q + 32'h1 >= limit);

  // Next mode: activity wins over any step-down
  // Forcing is a software override and also masks activity
  always_comb begin
    mode_d = mode_q;
    if (ctrl_q[PMS_CTRL_FORCE_BIT]) begin
      mode_d = pms_mode_t'(ctrl_q[PMS_CTRL_FMODE_LSB +: 2]);
    end else if (activity) begin
      mode_d = PMS_ACTIVE;
    end else if (step_due) begin
      case (mode_q)
        PMS_ACTIVE: mode_d = PMS_IDLE;
        PMS_IDLE:   mode_d = PMS_SLEEP;
        default:    mode_d = PMS_DEEP_OFF;
      endcase
    end
  end

  // Mode register
  // Reset lands in active mode so the core starts fully powered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= PMS_ACTIVE;
    else          mode_q <= mode_d;
  end

  // Inactivity counter; restarts on activity and on every mode change
  // Restarting on a mode change gives each mode its own full interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inact_q <= '0;
    end else if (activity || mode_d != mode_q) begin
      inact_q <= '0;
    end else if (lpo_en && mode_q != PMS_DEEP_OFF) begin
      inact_q <= inact_q + 32'h1;
    end
  end

  // Sniff interval used up on this slow tick
  assign sniff_due = (sniff_q + 32'h1 >= sniff_lim_q);

  // Sniff timer in slow-oscillator ticks; wake pulse when it expires
  // Clearing the enable stops the timer, so a later enable starts afresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sniff_q    <= '0;
      sniff_wake <= 1'b0;
    end else begin
      sniff_wake <= 1'b0;
      if (!ctrl_q[PMS_CTRL_SNIFF_BIT]) begin
        sniff_q <= '0;
      end else if (lpo_en) begin
        if (sniff_due) begin
          sniff_q    <= '0;
          sniff_wake <= 1'b1;
        end else begin
          sniff_q <= sniff_q + 32'h1;
        end
      end
    end
  end

  // Regulator cut only in deep-off and only with software consent
  assign reg_cut = (mode_d == PMS_DEEP_OFF) && ctrl_q[PMS_CTRL_REGDIS_BIT];
  // Slow clock in the two lowest modes and whenever sniff is enabled
  assign lpo_sel = (mode_d == PMS_SLEEP) ||
                   (mode_d == PMS_DEEP_OFF) ||
                   ctrl_q[PMS_CTRL_SNIFF_BIT];

  // Regulator and clock source; deep-off may cut regulator if software allows
  // Outputs follow mode_d so they change with power_mode, not a cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_output_en <= 1'b1;
      core_clk_sel_lpo    <= 1'b0;
      power_mode          <= 2'b00;
    end else begin
      regulator_output_en <= !reg_cut;
      core_clk_sel_lpo    <= lpo_sel;
      power_mode          <= mode_d;
    end
  end

  // Packet handler demand per radio path, in rf_pd bit order
  // The PLL must run whenever either path does, or the path cannot work
  always_comb begin
    rf_need                 = 4'h0;
    rf_need[PMS_RF_TX_BIT]  = pkt_tx_active;
    rf_need[PMS_RF_RX_BIT]  = pkt_rx_active;
    rf_need[PMS_RF_PLL_BIT] = pkt_pll_on || pkt_tx_active || pkt_rx_active;
    rf_need[PMS_RF_PA_BIT]  = pkt_tx_active;
  end

  // Radio only in active mode; every lower mode keeps all paths down
  assign radio_ok = (mode_d == PMS_ACTIVE);

  // One power-down flop per radio path; software bits override
  // A path is up only while the packet handler asks and software allows
  // Reset leaves every path down until software clears its bit
  for (genvar i = 0; i < 4; i++) begin : g_rf_path
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rf_pd_q[i] <= 1'b1;
      end else begin
        rf_pd_q[i] <= !(rf_need[i] && !rfctl_q[i] && radio_ok);
      end
    end
  end

  // Struct view for the transceiver, bits tx, rx, pll, pa from zero up
  assign rf_pd = pms_rf_pd_t'(rf_pd_q);

endmodule // pms_power_manager

// ==== testbench/pms_power_manager_props.sv ====
// Checker for the power mode sequencer, bound to the top module's ports.
// Assumes the single pclk domain with presetn as asynchronous reset.
`timescale 1ns/1ps
module pms_power_manager_props
  import pms_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       user_event,
  input wire logic       pkt_tx_active,
  input wire logic       pkt_rx_active,
  input wire logic       regulator_output_en,
  input wire logic       core_clk_sel_lpo,
  input wire logic       sniff_wake,
  input wire pms_rf_pd_t rf_pd,
  input wire logic [1:0] power_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Held activity outlasts the synchroniser latency
  sequence busy_s; user_event [*8]; endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("no pslverr");
  step_order_a: assert property ($changed(power_mode) && power_mode != 2'b00
    |-> power_mode == $past(power_mode) + 2'd1) else $error("mode skipped");
  wake_busy_a: assert property (busy_s |-> power_mode == 2'b00) else $error("no wake");
  reg_on_a: assert property (power_mode != 2'b11 && $past(power_mode) != 2'b11
    |-> regulator_output_en) else $error("regulator off");
  tx_down_a: assert property (!pkt_tx_active [*2] |-> rf_pd.tx_pd) else $error("tx up");
  rx_down_a: assert property (!pkt_rx_active [*2] |-> rf_pd.rx_pd) else $error("rx up");
  lpo_sleep_a: assert property (power_mode[1] && $past(power_mode[1])
    |-> core_clk_sel_lpo) else $error("not on slow clock");
  sniff_pulse_a: assert property (sniff_wake |=> !sniff_wake) else $error("long wake");
endmodule // pms_power_manager_props
bind pms_power_manager pms_power_manager_props u_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .user_event, .pkt_tx_active, .pkt_rx_active,
  .regulator_output_en, .core_clk_sel_lpo, .sniff_wake, .rf_pd, .power_mode);

// ==== testbench/pms_pkt_model.sv ====
// Packet handler model: one transmit then one receive burst per go pulse.
// Assumes go is a one-cycle pulse on pclk.
`timescale 1ns/1ps
module pms_pkt_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  output logic     pll_on,
  output logic     tx_on,
  output logic     rx_on
);
  logic [3:0] cnt_q;
  // Counter wraps to idle after one packet pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 4'h0;
    else cnt_q <= go ? 4'h1 : (cnt_q != 4'h0 ? cnt_q + 4'h1 : 4'h0);
  end
  // Tx and rx asked for only inside the burst windows; pll_on for the whole nonzero count
  assign pll_on = (cnt_q != 4'h0);
  assign tx_on  = (cnt_q >= 4'h2) && (cnt_q <= 4'h6);
  assign rx_on  = (cnt_q >= 4'h9) && (cnt_q <= 4'hd);
endmodule // pms_pkt_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the power mode sequencer over APB.
// Assumes a 125 MHz pclk and slow ticks made by toggling lpo_tick_in.
`timescale 1ns/1ps
module tb_top;
  import pms_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, user_event = 0, low_power_oscillator = 0, go = 0, reg_en, clk_lpo, wake;
  logic pll, tx, rx;
  pms_rf_pd_t rf_pd;
  logic [1:0] power_mode;
  int fail_count = 0, check_count = 0, wake_cnt = 0;
  pms_power_manager u_pms_power_manager (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .user_event, .lpo_tick_in(low_power_oscillator), .pkt_tx_active(tx),
    .pkt_rx_active(rx), .pkt_pll_on(pll), .regulator_output_en(reg_en),
    .core_clk_sel_lpo(clk_lpo), .sniff_wake(wake), .rf_pd, .power_mode);
  pms_pkt_model u_pms_pkt_model (.pclk, .presetn, .go, .pll_on(pll), .tx_on(tx), .rx_on(rx));
  initial forever #4 pclk = ~pclk;
  // Count sniff wake pulses, each one cycle long
  always @(posedge pclk) if (wake === 1'b1) wake_cnt++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // One slow oscillator period, long against the synchroniser
  task automatic tick();
    @(posedge pclk) low_power_oscillator <= 1'b1;
    repeat (6) @(posedge pclk);
    low_power_oscillator <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset();
    chk(power_mode, 0); chk(rf_pd, 4'hf); chk(reg_en, 1);
    apb(0, PMS_IDLE_OFS, 0); chk(rd, PMS_IDLE_RST);
    apb(0, 8'h1c, 0); chk(er, 1); chk(rd, 0);
  endtask
  // Activity between ticks must restart the interval
  task automatic t_steps();
    for (int a = 4; a <= 12; a += 4) apb(1, 8'(a), 2);
    apb(1, PMS_CTRL_OFS, 3);
    tick(); user_event <= 1; repeat (2) @(posedge pclk); user_event <= 0;
    repeat (8) @(posedge pclk); tick(); chk(power_mode, 0);
    for (int m = 1; m <= 3; m++) begin
      tick(); tick(); chk(power_mode, m);
    end
    chk(reg_en, 0); chk(clk_lpo, 1);
    user_event <= 1; repeat (8) @(posedge pclk);
    chk(power_mode, 0); chk(reg_en, 1); user_event <= 0;
  endtask
  task automatic t_radio();
    apb(1, PMS_RFCTL_OFS, 0);
    @(posedge pclk) go <= 1;
    @(posedge pclk) go <= 0;
    repeat (4) @(posedge pclk); #1 chk(rf_pd, 4'b0010);
    repeat (6) @(posedge pclk); #1 chk(rf_pd.rx_pd, 0); chk(rf_pd.tx_pd, 1);
    repeat (8) @(posedge pclk); #1 chk(rf_pd[1:0], 2'b11);
  endtask
  // A sniff wake pulse, a forced mode, then a reset in mid-run
  task automatic t_sniff();
    apb(1, PMS_SNIFF_OFS, 2);
    apb(1, PMS_CTRL_OFS, 4);
    tick(); tick(); chk(clk_lpo, 1); chk(wake_cnt, 1); chk(power_mode, 0);
    apb(1, PMS_CTRL_OFS, 32'h18);
    repeat (2) @(posedge pclk); #1 chk(power_mode, 1);
    apb(1, PMS_CTRL_OFS, 0); chk(power_mode, 1);
    user_event <= 1; repeat (8) @(posedge pclk);
    chk(power_mode, 0); user_event <= 0;
    presetn <= 0; repeat (2) @(posedge pclk); presetn <= 1;
    #1 chk(power_mode, 0); chk(rf_pd, 4'hf);
    apb(0, PMS_CTRL_OFS, 0); chk(rd, PMS_CTRL_RST);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset(); t_steps(); t_radio(); t_sniff();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    summarize();
  end
endmodule // tb_top
